// [pkg/irq_accept_pkg.sv]
// Constants, register map and carrier types for the interrupt acceptance unit.
// Assumes a single core clock and a plain strobe register port with 8-bit data.
package irq_accept_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int LEVEL_W = 3;
    localparam int SRC_N = 16;
    localparam int SRC_IDX_W = 4;

    // Interrupt control register layout
    localparam int ICR_LVL_LSB = 0;
    localparam int ICR_REQ_BIT = 3;
    localparam int ICR_POL_BIT = 4;
    localparam int ICR_EDGE_BIT = 5;
    localparam logic [DATA_W-1:0] ICR_RESET_MASK = 8'hF8;
    localparam logic [DATA_W-1:0] EXT_RESET_MASK = 8'hC8;

    // Flag register layout
    localparam int FLG_BANK_BIT = 4;
    localparam int FLG_IEN_BIT = 6;
    localparam int FLG_STK_BIT = 7;
    localparam int FLG_RSV_BIT = 5;
    localparam int FLG_IPL_LSB = 0;
    localparam logic [DATA_W-1:0] FLG_RESET = 8'h00;

    // Map: index of each source, its printed offset
    localparam logic [ADDR_W-1:0] OFS_FLASH_READY = 8'h41;
    localparam logic [ADDR_W-1:0] OFS_TIMER_C = 8'h47;
    localparam logic [ADDR_W-1:0] OFS_TIMER_E = 8'h4A;
    localparam logic [ADDR_W-1:0] OFS_SERIAL2_TX = 8'h4B;
    localparam logic [ADDR_W-1:0] OFS_SERIAL2_RX = 8'h4C;
    localparam logic [ADDR_W-1:0] OFS_KEY_INPUT = 8'h4D;
    localparam logic [ADDR_W-1:0] OFS_ANALOG = 8'h4E;
    localparam logic [ADDR_W-1:0] OFS_SYNC_SERIAL = 8'h4F;
    localparam logic [ADDR_W-1:0] OFS_SERIAL0_TX = 8'h51;
    localparam logic [ADDR_W-1:0] OFS_SERIAL0_RX = 8'h52;
    localparam logic [ADDR_W-1:0] OFS_TIMER_A = 8'h56;
    localparam logic [ADDR_W-1:0] OFS_TIMER_B = 8'h58;
    localparam logic [ADDR_W-1:0] OFS_EXT_PIN1 = 8'h59;
    localparam logic [ADDR_W-1:0] OFS_EXT_PIN0 = 8'h5D;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY_MON1 = 8'h72;
    localparam logic [ADDR_W-1:0] OFS_SUPPLY_MON2 = 8'h73;

    // Own registers
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h80;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h81;
    localparam logic [ADDR_W-1:0] OFS_IRQ_ENABLE = 8'h82;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h83;
    localparam logic [ADDR_W-1:0] OFS_LAST_SRC = 8'h84;

    // Event bits of the status register
    localparam int EV_ACCEPT = 0;
    localparam int EV_SOFT = 1;
    localparam int EV_BLOCKED = 2;
    localparam int EV_N = 3;

    localparam logic [SRC_N-1:0] EXT_PIN_MASK = 16'h3000;
    localparam logic [SRC_N*ADDR_W-1:0] SRC_OFS_TABLE = {
        OFS_SUPPLY_MON2, OFS_SUPPLY_MON1, OFS_EXT_PIN0, OFS_EXT_PIN1,
        OFS_TIMER_B, OFS_TIMER_A, OFS_SERIAL0_RX, OFS_SERIAL0_TX,
        OFS_SYNC_SERIAL, OFS_ANALOG, OFS_KEY_INPUT, OFS_SERIAL2_RX,
        OFS_SERIAL2_TX, OFS_TIMER_E, OFS_TIMER_C, OFS_FLASH_READY};

    localparam logic [5:0] SOFT_STK_LIMIT = 6'h1F;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic stack_sel;
        logic irq_en;
        logic bank_sel;
        logic [LEVEL_W-1:0] level;
    } flags_t;

    typedef struct packed {
        logic valid;
        logic [SRC_IDX_W-1:0] src;
        logic [LEVEL_W-1:0] level;
    } grant_t;

endpackage : irq_accept_pkg

// [hdl/irq_accept.sv]
// Interrupt acceptance unit: processor flags, per-source control registers,
// priority arbitration and flag update on acknowledge.
// Assumes the core pulses ack when it vectors and soft_int when it runs a
// software interrupt; source requests are synchronous to clk.
//
// Summary of operation
// - Maskable interrupts blocked while enable flag is 0, considered while 1.
// - Acknowledging any interrupt clears the enable flag; only ack clears it here, soft_int leaves it set.
// - Stack select 0 picks interrupt stack, 1 picks user stack.
// - Hardware acknowledge or software interrupt 0..31 clears stack select.
// - Processor priority level is a 3-bit field, levels 0 to 7.
// - Request taken only if its priority exceeds processor level strictly.
// - Reserved flag bit written 0 by software; reads undefined.
// - Peripheral control registers reset low three bits to zero.
// - External pin control registers reset bits 0-2, 4 and 5.
// - Two register banks exist; one is active at a time.
`timescale 1ns/100ps
module irq_accept #(
    parameter int SRC_N = irq_accept_pkg::SRC_N
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire irq_accept_pkg::reg_req_t reg_req,
    output logic [irq_accept_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [SRC_N-1:0] src_req,
    input wire logic ack,
    input wire logic soft_int,
    input wire logic [5:0] soft_vector,
    input wire logic flags_load,
    input wire irq_accept_pkg::flags_t flags_in,
    output irq_accept_pkg::grant_t grant,
    output logic use_user_stack,
    output logic active_bank,
    output logic [irq_accept_pkg::LEVEL_W-1:0] proc_level,
    output logic irq_out
);
    localparam int DW = irq_accept_pkg::DATA_W;
    localparam int LW = irq_accept_pkg::LEVEL_W;
    localparam int IW = irq_accept_pkg::SRC_IDX_W;
    localparam int EN = irq_accept_pkg::EV_N;

    // Offset table, reset masks and index width are sized for exactly this many sources
    generate
        if (SRC_N != irq_accept_pkg::SRC_N) begin : g_bad_src_n
            $error("SRC_N must match the register map");
        end
    endgenerate

    irq_accept_pkg::flags_t flags_q;
    irq_accept_pkg::flags_t flags_d;
    logic [DW-1:0] icr_q [SRC_N];
    logic [SRC_N-1:0] icr_hit;
    logic [SRC_N-1:0] pend;
    logic [LW-1:0] src_lvl [SRC_N];
    irq_accept_pkg::grant_t grant_d;
    irq_accept_pkg::grant_t grant_q;
    logic [EN-1:0] stat_q;
    logic [EN-1:0] en_q;
    logic [EN-1:0] ev;
    logic [IW-1:0] last_src_q;
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rdata_d;
    logic [DW-1:0] icr_rd;
    logic irq_q;
    logic rsv_q;
    logic [SRC_N-1:0] chain_valid;
    logic [IW-1:0] chain_src [SRC_N];
    logic [LW-1:0] chain_lvl [SRC_N];
    logic [DW-1:0] rd_chain [SRC_N];
    logic [EN-1:0] clr_mask;
    logic [EN-1:0] stat_d;
    logic [EN-1:0] en_d;
    logic [IW-1:0] last_src_d;
    logic rsv_d;
    logic irq_d;

    // Register decode
    wire wr_flags = reg_req.wr && reg_req.addr == irq_accept_pkg::OFS_FLAGS;
    wire wr_en = reg_req.wr && reg_req.addr == irq_accept_pkg::OFS_IRQ_ENABLE;
    wire wr_clr = reg_req.wr && reg_req.addr == irq_accept_pkg::OFS_IRQ_CLEAR;
    wire soft_low = soft_int && soft_vector <= irq_accept_pkg::SOFT_STK_LIMIT;

    // Per-source control registers and pending compare
    genvar g;
    generate
        for (g = 0; g < SRC_N; g++) begin : g_src
            localparam logic [DW-1:0] RMASK = irq_accept_pkg::EXT_PIN_MASK[g]
                ? irq_accept_pkg::EXT_RESET_MASK : irq_accept_pkg::ICR_RESET_MASK;
            assign icr_hit[g] = reg_req.addr ==
                irq_accept_pkg::SRC_OFS_TABLE[g*irq_accept_pkg::ADDR_W +: irq_accept_pkg::ADDR_W];
            assign src_lvl[g] = icr_q[g][irq_accept_pkg::ICR_LVL_LSB +: LW];
            assign pend[g] = src_req[g] && src_lvl[g] > flags_q.level;
            // Winner chain runs from the top index down so that a tie keeps the lower index
            if (g == SRC_N - 1) begin : g_top
                assign chain_valid[g] = pend[g];
                assign chain_src[g] = IW'(g);
                assign chain_lvl[g] = src_lvl[g];
                assign rd_chain[g] = icr_hit[g] ? icr_q[g] : '0;
            end else begin : g_link
                wire beats_above = pend[g]
                    && (!chain_valid[g+1] || src_lvl[g] >= chain_lvl[g+1]);
                assign chain_valid[g] = beats_above || chain_valid[g+1];
                assign chain_src[g] = beats_above ? IW'(g) : chain_src[g+1];
                assign chain_lvl[g] = beats_above ? src_lvl[g] : chain_lvl[g+1];
                assign rd_chain[g] = icr_hit[g] ? icr_q[g] : rd_chain[g+1];
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    icr_q[g] <= icr_q[g] & RMASK;
                end else if (clk_en && reg_req.wr && icr_hit[g]) begin
                    icr_q[g] <= reg_req.wdata;
                end
            end
        end
    endgenerate

    // Highest level wins; a blocked winner shows as all zero, not as a stale source
    wire grant_ok = chain_valid[0] && flags_q.irq_en;
    assign grant_d = grant_ok
        ? irq_accept_pkg::grant_t'{valid: 1'b1, src: chain_src[0], level: chain_lvl[0]}
        : '0;

    always_comb begin
        flags_d = flags_q;
        if (wr_flags) begin
            flags_d.level = reg_req.wdata[irq_accept_pkg::FLG_IPL_LSB +: LW];
            flags_d.bank_sel = reg_req.wdata[irq_accept_pkg::FLG_BANK_BIT];
            flags_d.irq_en = reg_req.wdata[irq_accept_pkg::FLG_IEN_BIT];
            flags_d.stack_sel = reg_req.wdata[irq_accept_pkg::FLG_STK_BIT];
        end
        if (flags_load) begin
            flags_d = flags_in;
        end
        if (ack) begin
            flags_d.irq_en = 1'b0;
            flags_d.stack_sel = 1'b0;
            flags_d.level = grant_q.level;
        end
        if (soft_low) begin
            flags_d.stack_sel = 1'b0;
        end
    end

    assign ev[irq_accept_pkg::EV_ACCEPT] = ack;
    assign ev[irq_accept_pkg::EV_SOFT] = soft_int;
    assign ev[irq_accept_pkg::EV_BLOCKED] = |pend && !flags_q.irq_en;

    // Own registers first, then the control register picked by the chain
    wire hit_flags = reg_req.addr == irq_accept_pkg::OFS_FLAGS;
    wire hit_status = reg_req.addr == irq_accept_pkg::OFS_IRQ_STATUS;
    wire hit_enable = reg_req.addr == irq_accept_pkg::OFS_IRQ_ENABLE;
    wire hit_last = reg_req.addr == irq_accept_pkg::OFS_LAST_SRC;
    wire [DW-1:0] flags_word = {flags_q.stack_sel, flags_q.irq_en, rsv_q, flags_q.bank_sel,
        1'b0, flags_q.level};
    assign icr_rd = rd_chain[0];
    assign rdata_d = !reg_req.rd ? '0
        : hit_flags ? flags_word
        : hit_status ? DW'(stat_q)
        : hit_enable ? DW'(en_q)
        : hit_last ? DW'(last_src_q)
        : icr_rd;

    assign clr_mask = wr_clr ? reg_req.wdata[EN-1:0] : '0;
    // Set beats clear when both land together
    assign stat_d = (stat_q & ~clr_mask) | ev;
    assign en_d = wr_en ? reg_req.wdata[EN-1:0] : en_q;
    assign last_src_d = ack ? grant_q.src : last_src_q;
    // Reserved bit just echoes the last write; software must treat it as undefined
    assign rsv_d = wr_flags ? reg_req.wdata[irq_accept_pkg::FLG_RSV_BIT] : rsv_q;
    // Built from next state so the pin follows the status bits with no extra lag
    assign irq_d = |(stat_d & en_d);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_q <= '0;
        end else if (clk_en) begin
            flags_q <= flags_d;
        end
    end

    // Acknowledged grant is dropped at once; the cleared enable keeps it down
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            grant_q <= '0;
        end else if (clk_en) begin
            grant_q <= ack ? '0 : grant_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat_q <= '0;
        end else if (clk_en) begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_q <= '0;
        end else if (clk_en) begin
            en_q <= en_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            last_src_q <= '0;
        end else if (clk_en) begin
            last_src_q <= last_src_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (clk_en) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsv_q <= 1'b0;
        end else if (clk_en) begin
            rsv_q <= rsv_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign grant = grant_q;
    assign use_user_stack = flags_q.stack_sel;
    assign active_bank = flags_q.bank_sel;
    assign proc_level = flags_q.level;
    assign irq_out = irq_q;

endmodule : irq_accept

// [tb/irq_accept_monitor.sv]
// Checker for flag updates and grant decisions of the acceptance unit.
// Sees only the ports of irq_accept; bound in at the foot of this file.
`timescale 1ns/100ps
module irq_accept_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire irq_accept_pkg::reg_req_t reg_req,
    input wire logic ack,
    input wire logic soft_int,
    input wire logic [5:0] soft_vector,
    input wire logic flags_load,
    input wire irq_accept_pkg::grant_t grant,
    input wire logic use_user_stack,
    input wire logic active_bank,
    input wire logic [irq_accept_pkg::LEVEL_W-1:0] proc_level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Plain flag writes only; ack and loads take precedence
    wire flag_wr = clk_en && reg_req.wr && reg_req.addr == irq_accept_pkg::OFS_FLAGS
        && !ack && !flags_load && !soft_int;
    wire take = clk_en && ack && grant.valid;
    ack_clear_a: assert property (take |=> !grant.valid)
        else $error("grant still valid after ack");
    lvl_take_a: assert property (take |=> proc_level == $past(grant.level))
        else $error("level not taken from grant");
    stack_ack_a: assert property (clk_en && ack |=> !use_user_stack)
        else $error("stack select kept on ack");
    soft_stack_a: assert property (clk_en && soft_int && soft_vector <= 6'h1F && !flags_load
        |=> !use_user_stack)
        else $error("stack select kept on soft interrupt");
    stack_sel_a: assert property (flag_wr |=> use_user_stack == $past(reg_req.wdata[7]))
        else $error("stack select mismatch");
    bank_sel_a: assert property (flag_wr |=> active_bank == $past(reg_req.wdata[4]))
        else $error("bank select mismatch");
    prio_strict_a: assert property (grant.valid |-> grant.level > $past(proc_level))
        else $error("grant level not above processor level");
    ien_block_a: assert property (flag_wr && !reg_req.wdata[6]
        |=> clk_en |-> ##1 !grant.valid)
        else $error("grant while interrupts disabled");
endmodule : irq_accept_monitor

bind irq_accept irq_accept_monitor irq_accept_monitor_i (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .reg_req(reg_req), .ack(ack), .soft_int(soft_int),
    .soft_vector(soft_vector), .flags_load(flags_load), .grant(grant),
    .use_user_stack(use_user_stack), .active_bank(active_bank), .proc_level(proc_level));

// [tb/irq_sources.sv]
// Behavioural peripheral request sources beside the acceptance unit.
// Assumes the bench pulses raise and drop on clk.
`timescale 1ns/100ps
module irq_sources (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] raise,
    input wire logic [15:0] drop,
    output logic [15:0] src_req
);
    // Level held until serviced, as a peripheral flag would be
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            src_req <= 16'h0000;
        end else begin
            src_req <= (src_req | raise) & ~drop;
        end
    end
endmodule : irq_sources

// [tb/tb_top.sv]
// Self-checking bench for the interrupt acceptance unit.
// Assumes the source model and the bound checker are compiled with it.
`timescale 1ns/100ps
module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    irq_accept_pkg::reg_req_t reg_req = '0;
    logic ack = 1'b0;
    logic clk_en = 1'b1;
    logic flags_load = 1'b0;
    irq_accept_pkg::flags_t flags_in = '0;
    logic soft_int = 1'b0;
    logic [5:0] soft_vector = 6'h00;
    logic [15:0] raise = 16'h0000;
    logic [15:0] drop = 16'h0000;
    logic [15:0] src_req;
    logic [7:0] reg_rdata;
    irq_accept_pkg::grant_t grant;
    logic use_user_stack;
    logic active_bank;
    logic [2:0] proc_level;
    logic irq_out;
    logic [7:0] v;
    int error_cnt = 0;
    int comparisons = 0;
    always #2.5 clk = ~clk;
    irq_sources irq_sources_i (.clk(clk), .sys_rst(sys_rst), .raise(raise), .drop(drop),
        .src_req(src_req));
    irq_accept irq_accept_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .src_req(src_req), .ack(ack), .soft_int(soft_int),
        .soft_vector(soft_vector), .flags_load(flags_load), .flags_in(flags_in), .grant(grant),
        .use_user_stack(use_user_stack), .active_bank(active_bank), .proc_level(proc_level),
        .irq_out(irq_out));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        reg_req <= '0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        reg_req <= '0;
        #1;
        v = reg_rdata;
    endtask : rd
    task automatic core(input logic a, input logic s, input logic [5:0] n);
        @(posedge clk);
        ack <= a;
        soft_int <= s;
        soft_vector <= n;
        @(posedge clk);
        ack <= 1'b0;
        soft_int <= 1'b0;
        cyc(2);
    endtask : core
    task automatic t_reset;
        rd(irq_accept_pkg::OFS_FLAGS);
        chk(v & 8'hDF, 8'h00);
        rd(irq_accept_pkg::OFS_ANALOG);
        chk(v & 8'h07, 8'h00);
        rd(irq_accept_pkg::OFS_EXT_PIN0);
        chk(v & 8'h37, 8'h00);
        rd(8'h60);
        chk(v, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_accept;
        wr(irq_accept_pkg::OFS_FLAGS, 8'hD3);
        wr(irq_accept_pkg::OFS_ANALOG, 8'h05);
        wr(irq_accept_pkg::OFS_IRQ_ENABLE, 8'h01);
        @(posedge clk);
        raise <= 16'h0040;
        @(posedge clk);
        raise <= 16'h0000;
        cyc(3);
        chk(grant, 8'hB5);
        chk({6'h00, active_bank, use_user_stack}, 8'h03);
        core(1'b1, 1'b0, 6'h00);
        chk(grant, 8'h00);
        chk({5'h00, proc_level}, 8'h05);
        chk({7'h00, use_user_stack}, 8'h00);
        rd(irq_accept_pkg::OFS_FLAGS);
        chk(v & 8'hDF, 8'h15);
        rd(irq_accept_pkg::OFS_IRQ_STATUS);
        chk(v & 8'h01, 8'h01);
        rd(irq_accept_pkg::OFS_LAST_SRC);
        chk(v, 8'h06);
        chk({7'h00, irq_out}, 8'h01);
        wr(irq_accept_pkg::OFS_IRQ_CLEAR, 8'h01);
        cyc(3);
        chk({7'h00, irq_out}, 8'h00);
        $display("t_accept done");
    endtask : t_accept
    task automatic t_strict;
        wr(irq_accept_pkg::OFS_FLAGS, 8'h45);
        cyc(3);
        chk(grant, 8'h00);
        wr(irq_accept_pkg::OFS_FLAGS, 8'h44);
        cyc(3);
        chk(grant, 8'hB5);
        wr(irq_accept_pkg::OFS_FLAGS, 8'h04);
        cyc(3);
        chk(grant, 8'h00);
        rd(irq_accept_pkg::OFS_IRQ_STATUS);
        chk(v & 8'h04, 8'h04);
        @(posedge clk);
        drop <= 16'h0040;
        @(posedge clk);
        drop <= 16'h0000;
        $display("t_strict done");
    endtask : t_strict
    task automatic t_soft;
        wr(irq_accept_pkg::OFS_FLAGS, 8'h80);
        core(1'b0, 1'b1, 6'h20);
        chk({7'h00, use_user_stack}, 8'h01);
        core(1'b0, 1'b1, 6'h1F);
        chk({7'h00, use_user_stack}, 8'h00);
        rd(irq_accept_pkg::OFS_IRQ_STATUS);
        chk(v & 8'h02, 8'h02);
        $display("t_soft done");
    endtask : t_soft
    // Frozen clock enable must ignore a write; a flag restore then loads every field
    task automatic t_hold;
        @(posedge clk);
        clk_en <= 1'b0;
        wr(irq_accept_pkg::OFS_FLAGS, 8'h07);
        cyc(2);
        chk({5'h00, proc_level}, 8'h00);
        @(posedge clk);
        clk_en <= 1'b1;
        flags_load <= 1'b1;
        flags_in <= '{stack_sel: 1'b1, irq_en: 1'b1, bank_sel: 1'b1, level: 3'h2};
        @(posedge clk);
        flags_load <= 1'b0;
        cyc(1);
        chk({2'h0, active_bank, use_user_stack, 1'b0, proc_level}, 8'h32);
        rd(irq_accept_pkg::OFS_FLAGS);
        chk(v & 8'hDF, 8'hD2);
        $display("t_hold done");
    endtask : t_hold
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset;
        t_accept;
        t_strict;
        t_soft;
        t_hold;
        end_of_test;
    end
    // Tests need under a hundred cycles; ample margin before giving up
    initial begin
        #20000;
        error_cnt++;
        end_of_test;
    end
endmodule : tb_top
